// >>> core/pcl_clock_ctrl.sv
// pll clock control: source select, multiplier, divider, lock and limp mode
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.svh"
// Notes on behaviour
// - four-bit multiplier: zero is bypass, 1..12 multiply the source
// - divider codes 0,1 divide by four, 2 by two, 3 by one; resets to four
// - multiplier and status reset only on power-up, pin or watchdog reset
// - nonzero multiplier write runs bypass until lock, then multiplied clock
// - multiplier zero routes source through divider, pll stays powered
// - power-down bit stops the pll, cpu runs from divided source
// - after power-up or pin reset the block runs in bypass
// - each internal oscillator selectable for watchdog, core and timer two
// - a select bit picks which of two pins carries external clock
// - the external clock disable bit forces the external clock low
// - lost source in bypass or enabled mode substitutes a limp clock
// - limp mode latches a failure nmi and sets missing clock flag
// - reset select: immediate reset or nmi watchdog overflow reset
// - multiplier register accepts writes only while unlocked
// - at power-up both internal oscillators run, oscillator one selected
module pcl_clock_ctrl #(
	parameter logic [`PCL_LOCK_W-1:0] LOCK_PERIOD = `PCL_LOCK_DEFAULT,
	parameter logic [`PCL_NMI_W-1:0]  NMI_PERIOD  = `PCL_NMI_DEFAULT
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   external_reset_pin_n,
	input  wire logic                   watchdog_reset,
	input  wire logic                   debug_reset,
	input  wire logic                   write_unlock_protection,
	input  wire logic                   multiplier_write,
	input  wire logic [`PCL_MULT_W-1:0] multiplier_wdata,
	input  wire logic                   prescale_write,
	input  wire logic [`PCL_DIV_W-1:0]  prescale_wdata,
	input  wire logic                   pll_power_down_in,
	input  wire pcl_pkg::pcl_src_t      core_src_sel,
	input  wire logic                   wdog_osc_two_sel,
	input  wire logic                   timer2_osc_two_sel,
	input  wire logic                   osc_one_off,
	input  wire logic                   osc_two_off,
	input  wire logic                   ext_clock_pin_select,
	input  wire logic                   ext_clock_disable,
	input  wire logic                   failure_reset_select,
	input  wire logic                   nmi_ack,
	input  wire logic                   internal_osc_one,
	input  wire logic                   internal_osc_two,
	input  wire logic                   crystal_clock,
	input  wire logic                   ext_pin_a,
	input  wire logic                   ext_pin_b,
	output logic [`PCL_MULT_W-1:0]      multiplier_control,
	output logic [`PCL_DIV_W-1:0]       output_prescale_select,
	output logic                        lock_done_flag,
	output logic                        pll_power_down,
	output logic                        pll_powered,
	output pcl_pkg::pcl_mode_t          mode,
	output logic [`PCL_MULT_W-1:0]      effective_mult,
	output logic                        system_clock_out,
	output logic                        external_clock_input,
	output logic                        wdog_clock,
	output logic                        timer2_clock,
	output logic                        osc_one_enabled,
	output logic                        osc_two_enabled,
	output logic                        clock_failure_signal,
	output logic                        missing_clock_flag,
	output logic                        limp_active,
	output logic                        device_reset
);
	////////////////////////////////////////////////////////////////////////
	logic pin_rst_s1;
	logic pin_rst_n;
	logic hard_rst;
	logic src_raw;
	logic src_lvl;
	logic src_rise;
	logic osc1_lvl;
	logic osc2_lvl;
	logic [`PCL_LOCK_W-1:0] lock_cnt;
	logic [`PCL_MISS_W-1:0] miss_cnt;
	logic [`PCL_NMI_W-1:0]  nmi_cnt;
	logic [`PCL_MISS_W-1:0] limp_cnt;
	logic [1:0] div_cnt;
	logic limp_clk;
	logic limp_event;

	// toggle after this many extra source rises: one rise per half period is /2
	function automatic logic [1:0] div_limit(input logic [`PCL_DIV_W-1:0] sel);
		if (sel == `PCL_DIV_BY2)
			div_limit = 2'h0;
		else
			div_limit = 2'h1;
	endfunction

	// external reset pin comes from outside: two flops before use
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_rst_s1 <= 1'b1;
			pin_rst_n  <= 1'b1;
		end else begin
			pin_rst_s1 <= external_reset_pin_n;
			pin_rst_n  <= pin_rst_s1;
		end
	end
	// debug and missing-clock resets deliberately excluded
	assign hard_rst = !resetn || !pin_rst_n || watchdog_reset;

	////////////////////////////////////////////////////////////////////////
	// source selection and external pin mux
	assign external_clock_input = ext_clock_disable ? 1'b0 :
		(ext_clock_pin_select ? ext_pin_b : ext_pin_a);
	always_comb begin
		unique case (core_src_sel)
			pcl_pkg::PCL_SRC_OSC1: src_raw = internal_osc_one;
			pcl_pkg::PCL_SRC_OSC2: src_raw = internal_osc_two;
			pcl_pkg::PCL_SRC_XTAL: src_raw = crystal_clock;
			pcl_pkg::PCL_SRC_EXT:  src_raw = external_clock_input;
		endcase
	end
	pcl_edge_sync u_src (
		.clk    (clk),
		.resetn (resetn),
		.din    (src_raw),
		.level  (src_lvl),
		.rise   (src_rise)
	);
	pcl_edge_sync u_osc1 (
		.clk    (clk),
		.resetn (resetn),
		.din    (internal_osc_one),
		.level  (osc1_lvl),
		.rise   ()
	);
	pcl_edge_sync u_osc2 (
		.clk    (clk),
		.resetn (resetn),
		.din    (internal_osc_two),
		.level  (osc2_lvl),
		.rise   ()
	);
	assign wdog_clock   = wdog_osc_two_sel ? osc2_lvl : osc1_lvl;
	assign timer2_clock = timer2_osc_two_sel ? osc2_lvl : osc1_lvl;
	// oscillators come up running; source select resets to oscillator one
	assign osc_one_enabled = !osc_one_off;
	assign osc_two_enabled = !osc_two_off;

	////////////////////////////////////////////////////////////////////////
	// multiplier, divider and power-down: survive debug and missing-clock reset
	always_ff @(posedge clk) begin
		if (hard_rst)
			multiplier_control <= `PCL_MULT_BYPASS;
		else if (multiplier_write && write_unlock_protection &&
			multiplier_wdata <= `PCL_MULT_MAX)
			multiplier_control <= multiplier_wdata;
	end
	always_ff @(posedge clk) begin
		if (hard_rst)
			output_prescale_select <= `PCL_DIV_RESET;
		else if (prescale_write && write_unlock_protection)
			output_prescale_select <= prescale_wdata;
	end
	always_ff @(posedge clk) begin
		if (hard_rst)
			pll_power_down <= 1'b0;
		else
			pll_power_down <= pll_power_down_in;
	end
	// lock period counted in source clock rising edges
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			lock_cnt       <= '0;
			lock_done_flag <= 1'b0;
		end else if (multiplier_write && write_unlock_protection) begin
			lock_cnt       <= '0;
			lock_done_flag <= 1'b0;
		end else if (pll_power_down) begin
			lock_done_flag <= 1'b0;
		end else if (!lock_done_flag && src_rise) begin
			if (lock_cnt == LOCK_PERIOD - 1'b1)
				lock_done_flag <= 1'b1;
			lock_cnt <= lock_cnt + 1'b1;
		end
	end
	assign pll_powered = !pll_power_down;
	always_comb begin
		if (pll_power_down)
			mode = pcl_pkg::PCL_OFF;
		else if (multiplier_control != `PCL_MULT_BYPASS && lock_done_flag)
			mode = pcl_pkg::PCL_LOCKED;
		else
			mode = pcl_pkg::PCL_BYPASS;
	end
	assign effective_mult = (mode == pcl_pkg::PCL_LOCKED) ? multiplier_control : `PCL_MULT_UNITY;

	////////////////////////////////////////////////////////////////////////
	// missing clock detection and limp clock
	always_ff @(posedge clk) begin
		if (!resetn || src_rise)
			miss_cnt <= '0;
		else if (miss_cnt != `PCL_MISS_LIMIT)
			miss_cnt <= miss_cnt + 1'b1;
	end
	assign limp_event = miss_cnt == `PCL_MISS_LIMIT && !pll_power_down && !limp_active;
	always_ff @(posedge clk) begin
		if (!resetn || !pin_rst_n || watchdog_reset)
			limp_active <= 1'b0;
		else if (limp_event)
			limp_active <= 1'b1;
	end
	always_ff @(posedge clk) begin
		if (!resetn || !pin_rst_n || watchdog_reset)
			missing_clock_flag <= 1'b0;
		else if (limp_event)
			missing_clock_flag <= 1'b1;
	end
	// set wins over acknowledge so a coincident failure is not lost
	always_ff @(posedge clk) begin
		if (!resetn || !pin_rst_n || watchdog_reset)
			clock_failure_signal <= 1'b0;
		else if (limp_event)
			clock_failure_signal <= 1'b1;
		else if (nmi_ack)
			clock_failure_signal <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (!resetn || !limp_active) begin
			limp_cnt <= '0;
			limp_clk <= 1'b0;
		end else if (limp_cnt == `PCL_LIMP_HALF) begin
			limp_cnt <= '0;
			limp_clk <= !limp_clk;
		end else
			limp_cnt <= limp_cnt + 1'b1;
	end
	always_ff @(posedge clk) begin
		if (!resetn || !clock_failure_signal)
			nmi_cnt <= '0;
		else if (nmi_cnt != NMI_PERIOD)
			nmi_cnt <= nmi_cnt + 1'b1;
	end
	// reset pulse only; debug reset is passed through too
	always_ff @(posedge clk) begin
		if (!resetn)
			device_reset <= 1'b0;
		else
			device_reset <= debug_reset ||
				(failure_reset_select ? limp_event :
				(clock_failure_signal && nmi_cnt == NMI_PERIOD - 1'b1));
	end

	////////////////////////////////////////////////////////////////////////
	// divided system clock: enable-style toggle from the selected edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_cnt          <= '0;
			system_clock_out <= 1'b0;
		end else if (limp_active && !pll_power_down) begin
			system_clock_out <= limp_clk;
		end else if (output_prescale_select == `PCL_DIV_BY1) begin
			// divide by one follows the synchronised source level
			system_clock_out <= src_lvl;
		end else if (src_rise) begin
			if (div_cnt >= div_limit(output_prescale_select)) begin
				div_cnt          <= '0;
				system_clock_out <= !system_clock_out;
			end else
				div_cnt <= div_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_LOCKED_NEEDS_FLAG: assert property (@(posedge clk) disable iff (!resetn)
		mode == pcl_pkg::PCL_LOCKED |->
		lock_done_flag && multiplier_control != `PCL_MULT_BYPASS)
		else $error("locked mode without lock");
	AST_WRITE_CLEARS_LOCK: assert property (@(posedge clk) disable iff (!resetn)
		multiplier_write && write_unlock_protection && !hard_rst |=> !lock_done_flag)
		else $error("lock flag survived a write");
	AST_PROTECTED: assert property (@(posedge clk) disable iff (!resetn)
		multiplier_write && !write_unlock_protection && !hard_rst
		|=> $stable(multiplier_control))
		else $error("protected write took effect");
	AST_EXT_OFF: assert property (@(posedge clk) disable iff (!resetn)
		ext_clock_disable |-> !external_clock_input)
		else $error("external clock not forced low");
	sequence s_fail;
		limp_event;
	endsequence
	AST_FAIL_FLAGS: assert property (@(posedge clk) disable iff (!resetn || hard_rst)
		s_fail |=> limp_active && missing_clock_flag && clock_failure_signal)
		else $error("failure not latched");
	AST_IMM_RESET: assert property (@(posedge clk) disable iff (!resetn)
		s_fail ##0 failure_reset_select |=> device_reset)
		else $error("no immediate reset");
	AST_OFF_MODE: assert property (@(posedge clk) disable iff (!resetn)
		pll_power_down |-> mode == pcl_pkg::PCL_OFF && !pll_powered)
		else $error("pll not off");
	AST_HARD_RESET: assert property (@(posedge clk) disable iff (!resetn)
		hard_rst |=> multiplier_control == `PCL_MULT_BYPASS &&
		output_prescale_select == `PCL_DIV_RESET)
		else $error("defaults not restored");
endmodule // pcl_clock_ctrl
`default_nettype wire

// >>> core/pcl_edge_sync.sv
// two-flop synchroniser with rising edge detect on the second stage
`timescale 1ns/100ps
`default_nettype none
module pcl_edge_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic din,
	output logic      level,
	output logic      rise
);
	logic meta;
	logic last;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta  <= 1'b0;
			level <= 1'b0;
			last  <= 1'b0;
		end else begin
			meta  <= din;
			level <= meta;
			last  <= level;
		end
	end
	assign rise = level & ~last;
endmodule // pcl_edge_sync
`default_nettype wire

// >>> include/pcl_defines.svh
// constants for the pll clock and limp mode block
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH
`define PCL_MULT_W        4
`define PCL_MULT_BYPASS   4'h0
`define PCL_MULT_MAX      4'hC
`define PCL_MULT_UNITY    4'h1
`define PCL_DIV_W         2
`define PCL_DIV_RESET     2'h0
`define PCL_DIV_BY2       2'h2
`define PCL_DIV_BY1       2'h3
`define PCL_LOCK_W        16
`define PCL_LOCK_DEFAULT  16'hFFFF
`define PCL_NMI_W         16
`define PCL_NMI_DEFAULT   16'h0FFF
`define PCL_MISS_W        8
`define PCL_MISS_LIMIT    8'h40
`define PCL_LIMP_HALF     8'h0F
`endif

// >>> include/pcl_pkg.sv
// types for the pll clock and limp mode block
package pcl_pkg;
	typedef enum logic [2:0] {
		PCL_OFF    = 3'h1,
		PCL_BYPASS = 3'h2,
		PCL_LOCKED = 3'h4
	} pcl_mode_t;
	typedef enum logic [1:0] {
		PCL_SRC_OSC1 = 2'h0,
		PCL_SRC_OSC2 = 2'h1,
		PCL_SRC_XTAL = 2'h2,
		PCL_SRC_EXT  = 2'h3
	} pcl_src_t;
endpackage

// >>> verif/pll_clock_and_limp_mode_test.sv
// self-checking bench for the pll clock and limp mode block
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.svh"
module pll_clock_and_limp_mode_test;
	logic	clk = 0, resetn = 0, external_reset_pin_n = 1, watchdog_reset = 0;
	logic	debug_reset = 0, write_unlock_protection = 0, multiplier_write = 0;
	logic	prescale_write = 0, pll_power_down_in = 0, wdog_osc_two_sel = 0;
	logic	timer2_osc_two_sel = 0, osc_one_off = 0, osc_two_off = 0, nmi_ack = 0;
	logic	ext_clock_pin_select = 0, ext_clock_disable = 0, failure_reset_select = 0;
	logic	internal_osc_one = 0, internal_osc_two = 0, crystal_clock = 0;
	logic	ext_pin_a = 0, ext_pin_b = 0, run1 = 1;
	logic [3:0]	multiplier_wdata = '0, multiplier_control, effective_mult;
	logic [1:0]	prescale_wdata = '0, output_prescale_select;
	pcl_pkg::pcl_src_t	core_src_sel = pcl_pkg::PCL_SRC_OSC1;
	pcl_pkg::pcl_mode_t	mode;
	logic	lock_done_flag, pll_power_down, pll_powered, system_clock_out;
	logic	external_clock_input, wdog_clock, timer2_clock, osc_one_enabled;
	logic	osc_two_enabled, clock_failure_signal, missing_clock_flag;
	logic	limp_active, device_reset;
	int	errors = 0, compares = 0, cyc = 0, i;

	// short lock and nmi counts keep the run brief
	pcl_clock_ctrl #(.LOCK_PERIOD(16'h0004), .NMI_PERIOD(16'h0014)) dut_u (
		.clk, .resetn, .external_reset_pin_n, .watchdog_reset, .debug_reset,
		.write_unlock_protection, .multiplier_write, .multiplier_wdata,
		.prescale_write, .prescale_wdata, .pll_power_down_in, .core_src_sel,
		.wdog_osc_two_sel, .timer2_osc_two_sel, .osc_one_off, .osc_two_off,
		.ext_clock_pin_select, .ext_clock_disable, .failure_reset_select, .nmi_ack,
		.internal_osc_one, .internal_osc_two, .crystal_clock, .ext_pin_a, .ext_pin_b,
		.multiplier_control, .output_prescale_select, .lock_done_flag,
		.pll_power_down, .pll_powered, .mode, .effective_mult, .system_clock_out,
		.external_clock_input, .wdog_clock, .timer2_clock, .osc_one_enabled,
		.osc_two_enabled, .clock_failure_signal, .missing_clock_flag,
		.limp_active, .device_reset);

	always #5 clk = ~clk;
	// source runs at an eighth of clk so the synchroniser sees every edge
	always @(posedge clk) begin
		#1;
		cyc++;
		if (run1 && cyc % 4 == 0) internal_osc_one = ~internal_osc_one;
		if (cyc > 5000) begin
			errors++;
			close_out();
		end
	end
	//////////////////////////////////////////////////////////////
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic hard_reset();
		resetn = 0;
		step(4);
		resetn = 1;
		step(1);
	endtask
	// divider is always back at zero before this is called
	// watchdog input stays idle around multiplier writes
	// the slow source stands in for a valid core frequency
	task automatic wr_mult(logic [3:0] v);
		multiplier_wdata = v;
		multiplier_write = 1;
		step(1);
		multiplier_write = 0;
		step(1);
	endtask
	// edges of the system clock over 64 cycles
	task automatic count_toggles(output int t);
		logic p;
		t = 0;
		p = system_clock_out;
		repeat (64) begin
			step(1);
			if (system_clock_out !== p) t++;
			p = system_clock_out;
		end
	endtask
	task automatic wr_div(logic [1:0] v);
		prescale_wdata = v;
		prescale_write = 1;
		step(1);
		prescale_write = 0;
		step(1);
	endtask
	//////////////////////////////////////////////////////////////
	task automatic t_reset();
		check("mult", multiplier_control, 16'h0);
		check("div", output_prescale_select, 16'h0);
		check("mode", mode, pcl_pkg::PCL_BYPASS);
		check("osc1", osc_one_enabled, 16'h1);
		check("osc2", osc_two_enabled, 16'h1);
	endtask
	task automatic t_mult();
		wr_mult(4'h5);
		check("locked", multiplier_control, 16'h0);
		write_unlock_protection = 1;
		wr_mult(4'h5);
		check("mult", multiplier_control, 16'h5);
		check("lock", lock_done_flag, 16'h0);
		check("mode", mode, pcl_pkg::PCL_BYPASS);
		for (i = 0; i < 200 && lock_done_flag !== 1'b1; i++) step(1);
		check("soon", i >= 20, 16'h1);
		check("mode", mode, pcl_pkg::PCL_LOCKED);
		check("emult", effective_mult, 16'h5);
		wr_mult(4'hD);
		check("over", multiplier_control, 16'h5);
		wr_mult(4'hC);
		check("max", multiplier_control, 16'hC);
		check("relock", lock_done_flag, 16'h0);
	endtask
	task automatic t_div();
		int t;
		for (t = 0; t < 200 && lock_done_flag !== 1'b1; t++) step(1);
		check("divlock", lock_done_flag, 16'h1);
		for (int c = 0; c < 4; c++) begin
			wr_div(c[1:0]);
			check("div", output_prescale_select, c[15:0]);
			count_toggles(t);
			check("rate", t, (c == 3) ? 16 : (c == 2) ? 8 : 4);
		end
		wr_div(2'h0);
	endtask
	task automatic t_resets();
		debug_reset = 1;
		step(2);
		debug_reset = 0;
		check("dbg", multiplier_control, 16'hC);
		watchdog_reset = 1;
		step(2);
		watchdog_reset = 0;
		step(2);
		check("wdg", multiplier_control, 16'h0);
		wr_mult(4'h3);
		external_reset_pin_n = 0;
		step(4);
		external_reset_pin_n = 1;
		step(4);
		check("pin", multiplier_control, 16'h0);
		check("pinmode", mode, pcl_pkg::PCL_BYPASS);
		check("pwr", pll_powered, 16'h1);
	endtask
	task automatic t_off();
		pll_power_down_in = 1;
		step(2);
		check("off", pll_power_down, 16'h1);
		check("offp", pll_powered, 16'h0);
		check("offm", mode, pcl_pkg::PCL_OFF);
		pll_power_down_in = 0;
		step(2);
		check("on", pll_powered, 16'h1);
	endtask
	task automatic t_ext();
		ext_pin_a = 1;
		step(4);
		check("pina", external_clock_input, 16'h1);
		ext_clock_pin_select = 1;
		step(4);
		check("pinb", external_clock_input, 16'h0);
		ext_pin_b = 1;
		step(4);
		check("pinb1", external_clock_input, 16'h1);
		ext_clock_disable = 1;
		step(4);
		check("dis", external_clock_input, 16'h0);
	endtask
	// oscillator two is driven high in the same step that both selects move to it
	task automatic t_osc();
		logic low = 0;
		internal_osc_two = 1;
		wdog_osc_two_sel = 1;
		timer2_osc_two_sel = 1;
		step(4);
		check("wd2", wdog_clock, 16'h1);
		check("t22", timer2_clock, 16'h1);
		wdog_osc_two_sel = 0;
		for (int n = 0; n < 16; n++) begin
			step(1);
			if (wdog_clock === 1'b0) low = 1;
		end
		check("wd1", low, 16'h1);
		check("t2hold", timer2_clock, 16'h1);
	endtask
	task automatic t_limp(logic sel, int lo, int hi);
		int n;
		failure_reset_select = sel;
		wr_mult(4'h5);
		run1 = 0;
		for (n = 0; n < 150 && limp_active !== 1'b1; n++) step(1);
		check("limp", limp_active, 16'h1);
		check("fail", clock_failure_signal, 16'h1);
		check("miss", missing_clock_flag, 16'h1);
		for (n = 0; n < 60 && device_reset !== 1'b1; n++) step(1);
		check("early", n >= lo, 16'h1);
		check("late", n <= hi, 16'h1);
		step(2);
		check("keep", multiplier_control, 16'h5);
		count_toggles(n);
		check("limpclk", n, 16'h4);
	endtask
	//////////////////////////////////////////////////////////////
	initial begin
		hard_reset();
		t_reset();
		t_mult();
		t_div();
		t_resets();
		t_off();
		t_ext();
		t_osc();
		t_limp(1'b1, 0, 2);
		run1 = 1;
		hard_reset();
		t_limp(1'b0, 17, 23);
		check("latch", clock_failure_signal, 16'h1);
		nmi_ack = 1;
		step(1);
		nmi_ack = 0;
		step(1);
		check("ack", clock_failure_signal, 16'h0);
		close_out();
	end
endmodule // pll_clock_and_limp_mode_test
`default_nettype wire
